// ---- design/watchdog_config_pkg.sv ----
// Constants shared by the watchdog configuration and protection logic.
package watchdog_config_pkg;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [1:0] CTRL_IDX   = 2'h0;
  localparam logic [1:0] STATUS_IDX = 2'h1;

  // Control register fields.
  localparam int WINDOW_MSB = 7;
  localparam int WINDOW_LSB = 4;
  localparam int PERIOD_MSB = 3;
  localparam int PERIOD_LSB = 0;

  // Status register fields.
  localparam int LOCK_BIT = 7;
  localparam int BUSY_BIT = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Field codes.
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_MAX = 4'hb;

  // The shortest timeout is 8 slow-clock cycles; each code step doubles it.
  localparam int          CNT_W      = 14;
  localparam logic [CNT_W-1:0] BASE_TICKS = 14'h0008;

  // Processor cycles for which a stored unlock key stays valid.
  localparam int UNLOCK_CYCLES = 4;

  // Slow-clock edges needed to carry a new control value across.
  localparam int SYNC_TICKS = 2;

  // Bus data width.
  localparam int DATA_W = 32;

  // Watchdog phases.
  typedef enum logic [1:0] {
    PH_OFF,
    PH_RUN,
    PH_CLOSED
  } phase_t;

endpackage

// ---- design/watchdog_config_protect_regs.sv ----
// Watchdog control and status registers with key unlock, lock and slow-clock timeout logic.
//
// Functional notes
// - Protected writes are always accepted but change nothing without a prior unlock.
// - Window, period and lock are key protected; the busy flag is not.
// - Control at index 0: window in bits 7:4, period 3:0; status at index 1.
// - A non-zero window field selects window mode and its closed duration.
// - Window codes 1 to 11 give 8 to 8K slow cycles, doubling; others reserved.
// - A non-zero period enables the watchdog; it is timeout or open window length.
// - Period codes 1 to 11 give 8 to 8K slow cycles; 0 disables it.
// - While lock is one, control writes are ignored.
// - Software may set lock; only a debug-mode write clears it.
// - Lock sets itself when the period is non-zero once boot completes.
// - Busy rises on each accepted control write and falls once the value has crossed.
// - Busy is read-only and needs no unlock.
// - Status resets to zero unless the automatic lock applies after boot.
// - No restart before the timeout issues a system reset; restart begins anew.
// - A restart during the closed window issues a system reset.
// - Timeouts count edges of the slow watchdog clock, asynchronous to clk_i.
// - The control register resets to the boot configuration word.
`timescale 1ns/1ps

module watchdog_config_protect_regs
  import watchdog_config_pkg::*;
#(
  parameter int UNLOCK_LEN = UNLOCK_CYCLES,
  parameter int SYNC_LEN   = SYNC_TICKS
)
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  // Avalon-MM slave, word addressed
  input  wire logic [1:0]        address_i,
  input  wire logic              read_i,
  input  wire logic              write_i,
  input  wire logic [DATA_W-1:0] writedata_i,
  input  wire logic [3:0]        byteenable_i,
  output logic [DATA_W-1:0]      readdata_o,
  output logic                   waitrequest_o,
  // System side
  input  wire logic              io_register_unlock_key_i,
  input  wire logic              watchdog_restart_instruction_i,
  input  wire logic              debug_mode_i,
  input  wire logic              boot_done_i,
  input  wire logic [7:0]        boot_config_word_i,
  input  wire logic              slow_watchdog_clock_i,
  // Watchdog result
  output logic                   system_reset_o
);

  // Timeout length of a code; reserved codes take the longest timeout.
  function automatic logic [CNT_W-1:0] code_ticks(input logic [3:0] code);
    logic [3:0] c;
    c = (code > CODE_MAX) ? CODE_MAX : code;
    code_ticks = BASE_TICKS << (c - 4'h1);
  endfunction

  logic [7:0]            ctrl_reg;
  logic [7:0]            active_ctrl_reg;
  logic                  lock_reg;
  logic                  busy_reg;
  logic [3:0]            unlock_cnt_reg;
  logic [3:0]            sync_cnt_reg;
  logic                  boot_seen_reg;
  logic                  waitreq_reg;
  logic [DATA_W-1:0]     rdata_reg;
  logic [2:0]            slow_sync_reg;
  logic                  slow_level_reg;
  logic                  slow_tick;
  logic [CNT_W-1:0]      cnt_reg;
  phase_t                phase_reg;
  logic                  rst_pulse_reg;
  logic                  wr_ok;
  logic                  unlocked;
  logic                  ctrl_wr;
  logic                  lock_set;
  logic                  lock_clr;
  logic                  window_on;
  logic                  enabled;

  assign wr_ok     = write_i & ~waitreq_reg & byteenable_i[0];
  assign unlocked  = (unlock_cnt_reg != 4'h0);
  assign window_on = (active_ctrl_reg[WINDOW_MSB:WINDOW_LSB] != CODE_OFF);
  assign enabled   = (active_ctrl_reg[PERIOD_MSB:PERIOD_LSB] != CODE_OFF);

  // Control takes a write only when unlocked, not locked and not still crossing.
  assign ctrl_wr  = wr_ok & (address_i == CTRL_IDX) & unlocked & ~lock_reg & ~busy_reg;
  assign lock_set = wr_ok & (address_i == STATUS_IDX) & unlocked & writedata_i[LOCK_BIT];
  assign lock_clr = wr_ok & (address_i == STATUS_IDX) & unlocked & ~writedata_i[LOCK_BIT]
                    & debug_mode_i;

  // One wait state: the slave answers on the second edge of every request.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      waitreq_reg <= 1'b1;
    end
    else
    begin
      waitreq_reg <= ~((read_i | write_i) & waitreq_reg);
    end
  end

  // Read data stand in the cycle in which waitrequest is low; unmapped reads give zero.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rdata_reg <= '0;
    end
    else if (read_i & waitreq_reg)
    begin
      rdata_reg <= '0;
      unique case (address_i)
        CTRL_IDX:
        begin
          rdata_reg[7:0] <= ctrl_reg;
        end
        STATUS_IDX:
        begin
          rdata_reg[LOCK_BIT] <= lock_reg;
          rdata_reg[BUSY_BIT] <= busy_reg;
        end
        default:
        begin
          rdata_reg <= '0;
        end
      endcase
    end
  end

  // Unlock window opened by the key; any protected access spends it.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      unlock_cnt_reg <= 4'h0;
    end
    else if (io_register_unlock_key_i)
    begin
      unlock_cnt_reg <= 4'(UNLOCK_LEN);
    end
    else if (wr_ok & unlocked)
    begin
      unlock_cnt_reg <= 4'h0;
    end
    else if (unlocked)
    begin
      unlock_cnt_reg <= unlock_cnt_reg - 4'h1;
    end
  end

  // Control register is loaded from the boot word by a synchronous reset.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_reg <= boot_config_word_i;
    end
    else if (ctrl_wr)
    begin
      ctrl_reg <= writedata_i[7:0];
    end
  end

  // Lock: software and the boot check may set it, a debug write clears it; setting wins.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      lock_reg      <= STATUS_RESET[LOCK_BIT];
      boot_seen_reg <= 1'b0;
    end
    else
    begin
      boot_seen_reg <= boot_seen_reg | boot_done_i;
      if (lock_set | (boot_done_i & ~boot_seen_reg & (ctrl_reg[PERIOD_MSB:PERIOD_LSB] != CODE_OFF)))
      begin
        lock_reg <= 1'b1;
      end
      else if (lock_clr)
      begin
        lock_reg <= 1'b0;
      end
    end
  end

  // Slow clock passes three flops; a rising edge counts once the last two agree on a new high level.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      slow_sync_reg  <= 3'h0;
      slow_level_reg <= 1'b0;
    end
    else
    begin
      slow_sync_reg <= {slow_sync_reg[1:0], slow_watchdog_clock_i};
      if (slow_sync_reg[2] == slow_sync_reg[1])
      begin
        slow_level_reg <= slow_sync_reg[2];
      end
    end
  end

  assign slow_tick = (slow_sync_reg[2] == slow_sync_reg[1]) & slow_sync_reg[2] & ~slow_level_reg;

  // Busy covers the crossing; the counting side takes the value after SYNC_LEN slow edges.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      busy_reg        <= STATUS_RESET[BUSY_BIT];
      sync_cnt_reg    <= 4'h0;
      active_ctrl_reg <= boot_config_word_i;
    end
    else if (ctrl_wr)
    begin
      busy_reg     <= 1'b1;
      sync_cnt_reg <= 4'(SYNC_LEN);
    end
    else if (busy_reg & slow_tick)
    begin
      if (sync_cnt_reg == 4'h1)
      begin
        busy_reg        <= 1'b0;
        active_ctrl_reg <= ctrl_reg;
      end
      sync_cnt_reg <= sync_cnt_reg - 4'h1;
    end
  end

  // Debug halt clears the counter; after it, or after enabling, the open phase counts toward the period timeout.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      phase_reg     <= PH_OFF;
      cnt_reg       <= '0;
      rst_pulse_reg <= 1'b0;
    end
    else
    begin
      rst_pulse_reg <= 1'b0;
      if (~enabled)
      begin
        phase_reg <= PH_OFF;
        cnt_reg   <= '0;
      end
      else if (debug_mode_i)
      begin
        phase_reg <= PH_RUN;
        cnt_reg   <= '0;
      end
      else if (phase_reg == PH_OFF)
      begin
        phase_reg <= PH_RUN;
        cnt_reg   <= '0;
      end
      else if (watchdog_restart_instruction_i)
      begin
        if (phase_reg == PH_CLOSED)
        begin
          rst_pulse_reg <= 1'b1;
          phase_reg     <= PH_RUN;
        end
        else
        begin
          phase_reg <= window_on ? PH_CLOSED : PH_RUN;
        end
        cnt_reg <= '0;
      end
      else if (slow_tick)
      begin
        if (phase_reg == PH_CLOSED)
        begin
          if (cnt_reg + 1'b1 >= code_ticks(active_ctrl_reg[WINDOW_MSB:WINDOW_LSB]))
          begin
            phase_reg <= PH_RUN;
            cnt_reg   <= '0;
          end
          else
          begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        else if (cnt_reg + 1'b1 >= code_ticks(active_ctrl_reg[PERIOD_MSB:PERIOD_LSB]))
        begin
          rst_pulse_reg <= 1'b1;
          cnt_reg       <= '0;
          phase_reg     <= PH_RUN;
        end
        else
        begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end

  assign readdata_o     = rdata_reg;
  assign waitrequest_o  = waitreq_reg;
  assign system_reset_o = rst_pulse_reg;

endmodule

// ---- verif/watchdog_config_protect_regs_assertions.sv ----
// Port-level assertions for the watchdog register block.
`timescale 1ns/1ps

module watchdog_config_protect_regs_checker
  import watchdog_config_pkg::*;
(
  // Clock, reset and bus
  input wire logic              clk_i,
  input wire logic              sys_rst_i,
  input wire logic [1:0]        address_i,
  input wire logic              read_i,
  input wire logic              write_i,
  input wire logic [DATA_W-1:0] readdata_o,
  input wire logic              waitrequest_o,
  // Watchdog result
  input wire logic              system_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  wait_once_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("request got no answer");
  wait_short_a: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low too long");
  upper_zero_a: assert property (readdata_o[31:8] == '0)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (read_i && !waitrequest_o && address_i[1] |-> readdata_o == '0)
    else $error("unmapped read not zero");
  status_gap_a: assert property (read_i && !waitrequest_o && address_i == STATUS_IDX |-> readdata_o[6:1] == '0)
    else $error("status spare bits set");
  data_hold_a: assert property (!(read_i && waitrequest_o) |=> $stable(readdata_o))
    else $error("read data moved without read");
  pulse_once_a: assert property (system_reset_o |=> !system_reset_o)
    else $error("reset pulse too long");
  boot_wait_a: assert property ($fell(sys_rst_i) |-> waitrequest_o)
    else $error("waitrequest low after reset");
endmodule

bind watchdog_config_protect_regs watchdog_config_protect_regs_checker chk_inst (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .system_reset_o(system_reset_o));

// ---- verif/watchdog_config_protect_regs_tb.sv ----
// Self-checking bench for the watchdog register block.
`timescale 1ns/1ps

module watchdog_config_protect_regs_tb;
  import watchdog_config_pkg::*;
  logic        clk_i = 0, sys_rst_i = 1, read_i = 0, write_i = 0;
  logic        key = 0, restart = 0, debug = 0, boot_done = 0, slow = 0;
  logic [1:0]  address_i = 0;
  logic [31:0] writedata_i = 0, readdata_o;
  logic [3:0]  byteenable_i = 4'hf;
  logic [7:0]  boot_i = 0, ctrl_m;
  logic        waitrequest_o, system_reset_o, lock_m = 0, busy_m = 0;
  int          seed, failures = 0, check_count = 0, cycles = 0, rst_cnt = 0, sync_m = 0, base;

  watchdog_config_protect_regs watchdog_config_protect_regs_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .io_register_unlock_key_i(key), .watchdog_restart_instruction_i(restart),
    .debug_mode_i(debug), .boot_done_i(boot_done), .boot_config_word_i(boot_i),
    .slow_watchdog_clock_i(slow), .system_reset_o(system_reset_o));

  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic summarize();
    if (failures == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The key pulse directly precedes the request so the write lands inside the unlock span.
  task automatic bus(input logic k, input logic w, input logic [1:0] a, input logic [7:0] d, output logic [31:0] q);
    if (k)
    begin
      key <= 1;
      @(posedge clk_i);
      key <= 0;
    end
    address_i <= a;
    writedata_i <= {24'($random(seed)), d};
    byteenable_i <= {3'($random(seed)), 1'b1};
    write_i <= w;
    read_i <= !w;
    do @(posedge clk_i); while (waitrequest_o !== 1'b0);
    q = readdata_o;
    write_i <= 0;
    read_i <= 0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic k, input logic [1:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(k, 1, a, d, q);
    if (k && a == CTRL_IDX && !lock_m && !busy_m)
    begin
      ctrl_m = d;
      busy_m = 1;
      sync_m = 0;
    end
    if (k && a == STATUS_IDX)
      lock_m = d[7] | (lock_m & !debug);
  endtask

  task automatic rd(input logic [1:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(0, 0, a, 8'h00, q);
    chk(q, exp);
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      slow <= 1;
      repeat (6) @(posedge clk_i);
      slow <= 0;
      repeat (6) @(posedge clk_i);
      sync_m++;
      if (sync_m == SYNC_TICKS)
        busy_m = 0;
    end
  endtask

  task automatic rs();
    restart <= 1;
    @(posedge clk_i);
    restart <= 0;
    @(posedge clk_i);
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (system_reset_o === 1'b1)
      rst_cnt++;
    if (cycles == 5000)
    begin
      failures++;
      summarize();
    end
  end

  initial
  begin
    seed = 32'hdbf62b0f;
    boot_i = 8'($random(seed)) | 8'h01;
    ctrl_m = boot_i;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 0;
    @(posedge clk_i);
    rd(CTRL_IDX, ctrl_m);
    rd(STATUS_IDX, 8'h00);
    boot_done <= 1;
    lock_m = 1;
    repeat (2) @(posedge clk_i);
    rd(STATUS_IDX, 8'h80);
    wr(1, CTRL_IDX, 8'h00);
    rd(CTRL_IDX, ctrl_m);
    wr(1, STATUS_IDX, 8'h00);
    rd(STATUS_IDX, 8'h80);
    debug <= 1;
    wr(1, STATUS_IDX, 8'h00);
    rd(STATUS_IDX, 8'h00);
    debug <= 0;
    // A key stored too long before the write has lapsed, so the write must not land.
    key <= 1;
    @(posedge clk_i);
    key <= 0;
    repeat (4) @(posedge clk_i);
    wr(0, CTRL_IDX, 8'h3c);
    rd(CTRL_IDX, ctrl_m);
    for (int c = 0; c < 16; c++)
    begin
      wr(1, CTRL_IDX, {c[3:0], 4'(15 - c)});
      rd(STATUS_IDX, {lock_m, 6'h0, busy_m});
      wr(1, CTRL_IDX, 8'h5a);
      tick(2);
      rd(CTRL_IDX, ctrl_m);
      rd(STATUS_IDX, {lock_m, 6'h0, busy_m});
    end
    wr(1, CTRL_IDX, 8'h01);
    tick(2);
    rs();
    base = rst_cnt;
    tick(6);
    rs();
    tick(6);
    chk(rst_cnt - base, 0);
    tick(4);
    chk(rst_cnt - base, 1);
    wr(1, CTRL_IDX, 8'h11);
    tick(2);
    rs();
    base = rst_cnt;
    tick(3);
    rs();
    repeat (8) @(posedge clk_i);
    chk(rst_cnt - base, 1);
    wr(1, 2'h3, 8'hff);
    rd(2'h2, 0);
    rd(2'h3, 0);
    wr(1, STATUS_IDX, 8'h80);
    rd(STATUS_IDX, 8'h80);
    summarize();
  end
endmodule
